/* src/dsv_gate.sv */
/*
 * Enable gate for exception bits: registered copy of the live
 * conditions while enabled, all zero while disabled.
 * Assumes conditions are level signals of the same clock.
 */
`timescale 1ns/10ps
module dsv_gate #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Conditions and enable
  input wire logic i_enable,
  input wire logic [WIDTH-1:0] i_cond,
  // Gated bits
  output logic [WIDTH-1:0] o_bits
);
  // No latching: bits follow the live condition every enabled cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bits <= '0;
    end else if (i_enable) begin
      o_bits <= i_cond;
    end else begin
      o_bits <= '0;
    end
  end
endmodule

/* src/dsv_map.svh */
/*
 * Register offsets, field positions, reset values and service codes of
 * the device supervisor. Assumes a 32-bit Avalon-MM slave port with byte
 * addresses, every register taking one aligned word.
 */
`ifndef DSV_MAP_SVH
`define DSV_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DSV_OFS_CMD        6'h00
`define DSV_OFS_RESULT     6'h04
`define DSV_OFS_STATE      6'h08
`define DSV_OFS_ENABLE     6'h0c
`define DSV_OFS_EXC_STAT   6'h10
`define DSV_OFS_WDET_COM   6'h14
`define DSV_OFS_WDET_DEVA  6'h18
`define DSV_OFS_WDET_DEVB  6'h1c
`define DSV_OFS_WDET_MFR   6'h20

// ****************************************************************
// Service codes
// ****************************************************************
`define DSV_SVC_RESET      8'h05
`define DSV_SVC_START      8'h06
`define DSV_SVC_STOP       8'h07
`define DSV_SVC_GET        8'h0e
`define DSV_SVC_SET        8'h10
`define DSV_SVC_ABORT      8'h4b
`define DSV_SVC_RECOVER    8'h4c
`define DSV_SVC_DIAG       8'h4e

// ****************************************************************
// Answer status codes
// ****************************************************************
`define DSV_ST_OK          8'h00
`define DSV_ST_NO_SVC      8'h08
`define DSV_ST_BAD_VALUE   8'h09
`define DSV_ST_CONFLICT    8'h0c
`define DSV_ST_NOT_SET     8'h0e
`define DSV_ST_NO_ATTR     8'h14

// ****************************************************************
// Attribute identifiers reachable by get and set
// ****************************************************************
`define DSV_ATTR_STATE     8'h0b
`define DSV_ATTR_EXC_STAT  8'h0c
`define DSV_ATTR_ALARM_EN  8'h0d
`define DSV_ATTR_WARN_EN   8'h0e

// ****************************************************************
// Field positions
// ****************************************************************
`define DSV_EN_ALARM_BIT   0
`define DSV_EN_WARN_BIT    1
`define DSV_EXC_EXPANDED   7
`define DSV_EXC_W_COMMON   4
`define DSV_EXC_W_DEVICE   5
`define DSV_EXC_W_MFR      6
`define DSV_COM_DATA_BIT   4
`define DSV_COM_NVM_BIT    3
`define DSV_COM_CODE_BIT   2
`define DSV_MFR_SERCOM_BIT 0
`define DSV_DET_PRESENT    31
`define DSV_EXT_INVALID    0
`define DSV_EXT_OVER       1
`define DSV_EXT_UNDER      2

// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define DSV_COM_SIZE       8'h02
`define DSV_DEV_SIZE_TWO   8'h05
`define DSV_DEV_SIZE_ONE   8'h03
`define DSV_MFR_SIZE       8'h01
`define DSV_ALARM_EN_RST   1'b1
`define DSV_WARN_EN_RST    1'b1

`endif

/* src/dsv_pkg.sv */
/*
 * Types shared by the device supervisor files.
 * Assumes dsv_map.svh supplies the numeric constants.
 */
package dsv_pkg;

  typedef enum logic [2:0] {
    DSV_SELFTEST,
    DSV_IDLE,
    DSV_EXECUTING,
    DSV_ABORT,
    DSV_CRIT_FAULT
  } dsv_state_t;

  // Command word as written to the command register
  typedef struct packed {
    logic [7:0] rsvd;
    logic [7:0] value;
    logic [7:0] attr;
    logic [7:0] code;
  } dsv_cmd_t;

  // Raw warning conditions from the surrounding device
  typedef struct packed {
    logic [2:0] mem;
    logic [7:0] s1_ext;
    logic [7:0] s1_w0;
    logic [7:0] s1_w1;
    logic [7:0] s2_w0;
    logic [7:0] s2_w1;
    logic sercom;
  } dsv_warn_t;

endpackage

/* src/dsv_rst_sync.sv */
/*
 * Reset release synchroniser.
 * Assumes an asynchronous active-low reset; assertion is immediate,
 * release is delayed two clock edges.
 */
`timescale 1ns/10ps
module dsv_rst_sync (
  // Clock and raw reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Synchronised reset
  output logic o_rst_n
);
  logic meta_r;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      o_rst_n <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      o_rst_n <= meta_r;
    end
  end
endmodule

/* src/dsv_supervisor.sv */
/*
 * Device supervisor: state machine driven by supervisor services,
 * warning exception detail assembly and alarm/warning enable gating.
 * Assumes a 32-bit Avalon-MM master with byte addresses, and that the
 * network layer, sensors, self-test and diagnostic engines run on the
 * same clock and present single-cycle event pulses.
 */
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
// Functional notes
// - Common warning detail is two bytes
// - Common byte0 flags data, nonvolatile, code memory
// - Common warning byte one always zero
// - Device warning size five or three bytes
// - Device byte0 is sensor one status extension
// - Device bytes one, two: sensor one warnings
// - Device bytes three, four: sensor two warnings
// - Manufacturer warning one byte, serial comm flag
// - Enable flags gate exception bit setting
// - Clearing an enable clears its bits
// - Exception bits follow live conditions, no latch
// - Both enables reset to one
// - Power-up or reset service enters self-test
// - Diagnostics accepted except critical fault, abort
// - Abort request moves to aborted state
// - Recover moves from abort to idle
// - Get returns, set updates an attribute
// - Start runs, stop places device idle
// - Idle to executing on start or I/O
// - Detail present only with expanded and type bit
// - Status extension: invalid, overrange, underrange bits
// - Abort, recover, diagnostics codes decoded
`timescale 1ns/10ps
`include "dsv_map.svh"
module dsv_supervisor
  import dsv_pkg::*;
#(
  parameter int NUM_SENSORS = 2
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Internal events from application objects
  input wire logic i_int_abort,
  input wire logic i_int_recover,
  input wire logic i_io_data_valid,
  input wire logic i_selftest_done,
  input wire logic i_selftest_pass,
  input wire logic i_crit_fault,
  // Live exception conditions
  input wire logic [2:0] i_alarm_cond,
  input wire logic [2:0] i_mem_warn,
  input wire logic [7:0] i_s1_status_ext,
  input wire logic [7:0] i_s1_warn0,
  input wire logic [7:0] i_s1_warn1,
  input wire logic [7:0] i_s2_warn0,
  input wire logic [7:0] i_s2_warn1,
  input wire logic i_serial_comm_warning_flag,
  // Supervisor outputs
  output dsv_state_t o_state,
  output logic o_executing,
  output logic o_selftest_start,
  output logic o_diag_start,
  output logic [7:0] o_diagnostic_test_selector
);

  // ****************************************************************
  // Reset and gating instances
  // ****************************************************************
  localparam int WARN_W = $bits(dsv_warn_t);

  logic rst_n;
  logic alarm_en_r;
  logic warn_en_r;
  logic [2:0] alarm_g;
  dsv_warn_t warn_raw;
  dsv_warn_t warn_g;

  dsv_rst_sync u_rst_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .o_rst_n(rst_n)
  );

  always_comb begin
    warn_raw.mem = i_mem_warn;
    warn_raw.s1_ext = i_s1_status_ext;
    warn_raw.s1_w0 = i_s1_warn0;
    warn_raw.s1_w1 = i_s1_warn1;
    warn_raw.s2_w0 = (NUM_SENSORS > 1) ? i_s2_warn0 : 8'h00;
    warn_raw.s2_w1 = (NUM_SENSORS > 1) ? i_s2_warn1 : 8'h00;
    warn_raw.sercom = i_serial_comm_warning_flag;
  end

  dsv_gate #(
    .WIDTH(3)
  ) u_alarm_gate (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_enable(alarm_en_r),
    .i_cond(i_alarm_cond),
    .o_bits(alarm_g)
  );

  // Disabled enable zeroes bits on the next edge
  dsv_gate #(
    .WIDTH(WARN_W)
  ) u_warn_gate (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_enable(warn_en_r),
    .i_cond(warn_raw),
    .o_bits(warn_g)
  );

  // ****************************************************************
  // Avalon-MM handshake
  // ****************************************************************
  logic ack_r;
  logic req;
  logic acc_wr;
  logic lane0;
  logic svc_fire;
  logic [5:0] word_addr;
  dsv_cmd_t cmd;

  assign req = i_avs_read | i_avs_write;
  // One wait cycle so read data come from a flip-flop
  assign o_avs_waitrequest = req & ~ack_r;
  assign acc_wr = i_avs_write & ack_r;
  assign lane0 = i_avs_byteenable[0];
  assign word_addr = {i_avs_address[5:2], 2'b00};
  assign cmd = dsv_cmd_t'(i_avs_writedata);
  assign svc_fire = acc_wr & lane0 & (word_addr == `DSV_OFS_CMD);

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ****************************************************************
  // Exception status and warning detail
  // ****************************************************************
  logic [7:0] exc_stat;
  logic [7:0] com_b0;
  logic [7:0] mfr_b0;
  logic [7:0] dev_size;
  logic w_com_on;
  logic w_dev_on;
  logic w_mfr_on;

  always_comb begin
    com_b0 = 8'h00;
    com_b0[`DSV_COM_DATA_BIT] = warn_g.mem[2];
    com_b0[`DSV_COM_NVM_BIT] = warn_g.mem[1];
    com_b0[`DSV_COM_CODE_BIT] = warn_g.mem[0];
    mfr_b0 = 8'h00;
    mfr_b0[`DSV_MFR_SERCOM_BIT] = warn_g.sercom;
  end

  assign dev_size = (NUM_SENSORS > 1) ? `DSV_DEV_SIZE_TWO
                                      : `DSV_DEV_SIZE_ONE;

  always_comb begin
    exc_stat = 8'h00;
    exc_stat[2:0] = alarm_g;
    exc_stat[`DSV_EXC_W_COMMON] = |com_b0;
    exc_stat[`DSV_EXC_W_DEVICE] = |{warn_g.s1_ext, warn_g.s1_w0,
      warn_g.s1_w1, warn_g.s2_w0, warn_g.s2_w1};
    exc_stat[`DSV_EXC_W_MFR] = |mfr_b0;
    exc_stat[`DSV_EXC_EXPANDED] = 1'b1;
  end

  assign w_com_on = exc_stat[`DSV_EXC_EXPANDED] &
                    exc_stat[`DSV_EXC_W_COMMON];
  assign w_dev_on = exc_stat[`DSV_EXC_EXPANDED] &
                    exc_stat[`DSV_EXC_W_DEVICE];
  assign w_mfr_on = exc_stat[`DSV_EXC_EXPANDED] &
                    exc_stat[`DSV_EXC_W_MFR];

  // ****************************************************************
  // Supervisor state machine
  // ****************************************************************
  dsv_state_t state_r;
  dsv_state_t state_nxt;
  logic [7:0] svc_status;
  logic [7:0] get_value;
  logic selftest_go;
  logic diag_go;
  logic set_alarm;
  logic set_warn;

  always_comb begin
    state_nxt = state_r;
    svc_status = `DSV_ST_OK;
    get_value = 8'h00;
    selftest_go = 1'b0;
    diag_go = 1'b0;
    set_alarm = 1'b0;
    set_warn = 1'b0;
    // Application-side events
    case (state_r)
      DSV_SELFTEST: begin
        if (i_selftest_done) begin
          state_nxt = i_selftest_pass ? DSV_IDLE : DSV_CRIT_FAULT;
        end
      end
      DSV_IDLE: begin
        if (i_int_abort) begin
          state_nxt = DSV_ABORT;
        end else if (i_io_data_valid) begin
          state_nxt = DSV_EXECUTING;
        end
      end
      DSV_EXECUTING: begin
        if (i_int_abort) begin
          state_nxt = DSV_ABORT;
        end
      end
      DSV_ABORT: begin
        if (i_int_recover) begin
          state_nxt = DSV_IDLE;
        end
      end
      DSV_CRIT_FAULT: begin
        state_nxt = DSV_CRIT_FAULT;
      end
      default: begin
        state_nxt = DSV_CRIT_FAULT;
      end
    endcase
    // Bus services take precedence over the events above
    if (svc_fire) begin
      case (cmd.code)
        `DSV_SVC_RESET: begin
          if (state_r != DSV_CRIT_FAULT) begin
            state_nxt = DSV_SELFTEST;
            selftest_go = 1'b1;
          end else begin
            svc_status = `DSV_ST_CONFLICT;
          end
        end
        `DSV_SVC_DIAG: begin
          if (state_r != DSV_CRIT_FAULT && state_r != DSV_ABORT) begin
            state_nxt = DSV_SELFTEST;
            diag_go = 1'b1;
          end else begin
            svc_status = `DSV_ST_CONFLICT;
          end
        end
        `DSV_SVC_START: begin
          if (state_r == DSV_IDLE || state_r == DSV_EXECUTING) begin
            state_nxt = DSV_EXECUTING;
          end else begin
            svc_status = `DSV_ST_CONFLICT;
          end
        end
        `DSV_SVC_STOP: begin
          if (state_r == DSV_IDLE || state_r == DSV_EXECUTING) begin
            state_nxt = DSV_IDLE;
          end else begin
            svc_status = `DSV_ST_CONFLICT;
          end
        end
        `DSV_SVC_ABORT: begin
          if (state_r == DSV_IDLE || state_r == DSV_EXECUTING ||
              state_r == DSV_ABORT) begin
            state_nxt = DSV_ABORT;
          end else begin
            svc_status = `DSV_ST_CONFLICT;
          end
        end
        `DSV_SVC_RECOVER: begin
          if (state_r == DSV_ABORT) begin
            state_nxt = DSV_IDLE;
          end else begin
            svc_status = `DSV_ST_CONFLICT;
          end
        end
        `DSV_SVC_GET: begin
          case (cmd.attr)
            `DSV_ATTR_STATE: get_value = {5'h00, state_r};
            `DSV_ATTR_EXC_STAT: get_value = exc_stat;
            `DSV_ATTR_ALARM_EN: get_value = {7'h00, alarm_en_r};
            `DSV_ATTR_WARN_EN: get_value = {7'h00, warn_en_r};
            default: svc_status = `DSV_ST_NO_ATTR;
          endcase
        end
        `DSV_SVC_SET: begin
          case (cmd.attr)
            `DSV_ATTR_ALARM_EN, `DSV_ATTR_WARN_EN: begin
              if (cmd.value[7:1] != 7'h00) begin
                svc_status = `DSV_ST_BAD_VALUE;
              end else begin
                set_alarm = (cmd.attr == `DSV_ATTR_ALARM_EN);
                set_warn = (cmd.attr == `DSV_ATTR_WARN_EN);
              end
            end
            `DSV_ATTR_STATE, `DSV_ATTR_EXC_STAT: begin
              svc_status = `DSV_ST_NOT_SET;
            end
            default: svc_status = `DSV_ST_NO_ATTR;
          endcase
        end
        default: svc_status = `DSV_ST_NO_SVC;
      endcase
    end
    // A detected critical fault overrides every next state chosen above
    if (i_crit_fault) begin
      state_nxt = DSV_CRIT_FAULT;
    end
  end

  // Power-up lands in self-test through the reset value
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= DSV_SELFTEST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Enable flags
  // ****************************************************************
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      alarm_en_r <= `DSV_ALARM_EN_RST;
      warn_en_r <= `DSV_WARN_EN_RST;
    end else if (set_alarm) begin
      alarm_en_r <= cmd.value[0];
    end else if (set_warn) begin
      warn_en_r <= cmd.value[0];
    end else if (acc_wr && lane0 && word_addr == `DSV_OFS_ENABLE) begin
      alarm_en_r <= i_avs_writedata[`DSV_EN_ALARM_BIT];
      warn_en_r <= i_avs_writedata[`DSV_EN_WARN_BIT];
    end
  end

  // ****************************************************************
  // Service answer and start pulses
  // ****************************************************************
  logic [15:0] result_r;
  logic post_rst_r;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= 16'h0000;
    end else if (svc_fire) begin
      result_r <= {svc_status, get_value};
    end
  end

  // Self-test also starts once after reset release
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      post_rst_r <= 1'b1;
      o_selftest_start <= 1'b0;
      o_diag_start <= 1'b0;
      o_diagnostic_test_selector <= 8'h00;
    end else begin
      post_rst_r <= 1'b0;
      o_selftest_start <= selftest_go | post_rst_r;
      o_diag_start <= diag_go;
      if (diag_go) begin
        o_diagnostic_test_selector <= cmd.attr;
      end
    end
  end

  // Valid measurements only flow while executing
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_state <= DSV_SELFTEST;
      o_executing <= 1'b0;
    end else begin
      o_state <= state_nxt;
      o_executing <= (state_nxt == DSV_EXECUTING);
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (word_addr)
      `DSV_OFS_RESULT: rd_nxt = {16'h0000, result_r};
      `DSV_OFS_STATE: rd_nxt = {29'h0000_0000, state_r};
      `DSV_OFS_ENABLE: rd_nxt = {30'h0000_0000, warn_en_r, alarm_en_r};
      `DSV_OFS_EXC_STAT: rd_nxt = {24'h00_0000, exc_stat};
      `DSV_OFS_WDET_COM: begin
        if (w_com_on) begin
          // Second common byte is always zero
          rd_nxt = {8'h80, 8'h00, com_b0, `DSV_COM_SIZE};
        end
      end
      `DSV_OFS_WDET_DEVA: begin
        if (w_dev_on) begin
          rd_nxt = {warn_g.s1_w1, warn_g.s1_w0, warn_g.s1_ext, dev_size};
        end
      end
      `DSV_OFS_WDET_DEVB: begin
        if (w_dev_on) begin
          rd_nxt = {8'h80, 8'h00, warn_g.s2_w1, warn_g.s2_w0};
        end
      end
      `DSV_OFS_WDET_MFR: begin
        if (w_mfr_on) begin
          rd_nxt = {8'h80, 8'h00, mfr_b0, `DSV_MFR_SIZE};
        end
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack_r) begin
      o_avs_readdata <= rd_nxt;
    end
  end

endmodule

/* test/dsv_master_model.sv */
/*
 * Fieldbus master model: explicit services over Avalon-MM, I/O polls.
 * Assumes the supervisor clock; one transfer at a time.
 */
`timescale 1ns/10ps
module dsv_master_model (
  // Clock and bus answer
  input wire logic i_clock,
  input wire logic [31:0] i_rdata,
  input wire logic i_wait,
  // Bus request
  output logic [5:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata,
  output logic [3:0] o_be,
  // Poll data
  output logic o_io_valid
);
  initial {o_addr, o_rd, o_wr, o_wdata, o_be, o_io_valid} = '0;
  task automatic xfer(input logic w, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    o_addr <= a;
    o_wdata <= d;
    o_be <= 4'hf;
    o_wr <= w;
    o_rd <= !w;
    // Waitrequest is taken at the rising edge only
    do begin
      @(posedge i_clock);
    end while (i_wait);
    q = i_rdata;
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    // Released address and data lines never keep the last value
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // Poll before expecting values
  task automatic io_poll();
    @(posedge i_clock);
    o_io_valid <= 1'b1;
    @(posedge i_clock);
    o_io_valid <= 1'b0;
  endtask
endmodule

/* test/dsv_props.sv */
/*
 * Port checker for the device supervisor, bound to its module.
 * Assumes one clock and the raw active-low reset at the ports.
 */
`timescale 1ns/10ps
module dsv_props
  import dsv_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Watched signals
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_crit_fault,
  input wire dsv_state_t o_state,
  input wire logic o_executing,
  input wire logic o_selftest_start,
  input wire logic o_diag_start
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ****************************************
  // Bus handshake
  // ****************************************
  a_wait_first: assert property ($rose(i_avs_read | i_avs_write)
    |-> o_avs_waitrequest) else $error("no wait cycle");
  a_wait_one: assert property ((i_avs_read | i_avs_write)
    && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("wait long");
  a_rdata_hold: assert property (!(i_avs_read &&
    o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data moved");
  // ****************************************
  // State machine
  // ****************************************
  a_exec_flag: assert property (o_executing ==
    (o_state == DSV_EXECUTING)) else $error("executing flag wrong");
  a_test_pulse: assert property (o_selftest_start |->
    o_state == DSV_SELFTEST ##1 !o_selftest_start)
    else $error("self-test pulse wrong");
  a_diag_pulse: assert property (o_diag_start |->
    o_state == DSV_SELFTEST ##1 !o_diag_start)
    else $error("diagnostic pulse wrong");
  a_crit_stay: assert property (o_state == DSV_CRIT_FAULT |=>
    o_state == DSV_CRIT_FAULT) else $error("left critical fault");
  a_crit_force: assert property (i_crit_fault |=> ##[0:1]
    o_state == DSV_CRIT_FAULT) else $error("fault not entered");
  a_abort_exit: assert property (o_state == DSV_ABORT ##1
    o_state != DSV_ABORT |-> o_state inside {DSV_IDLE, DSV_SELFTEST,
    DSV_CRIT_FAULT}) else $error("bad abort exit");
  c_abort: cover property (o_state == DSV_ABORT);
  c_diag: cover property (o_diag_start);
  c_crit: cover property (o_state == DSV_CRIT_FAULT);
endmodule

bind dsv_supervisor dsv_props dsv_props_i (.i_clock, .i_rst_n,
  .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
  .i_crit_fault, .o_state, .o_executing, .o_selftest_start,
  .o_diag_start);

/* test/dsv_supervisor_test.sv */
/*
 * Self-checking bench of the device supervisor.
 * Assumes the master model and the bound checker.
 */
`timescale 1ns/10ps
`include "dsv_map.svh"
module dsv_supervisor_test
  import dsv_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [5:0] addr;
  logic rd_r, wr_r, io, wait_r;
  logic [31:0] wdat, rdat;
  logic [3:0] be;
  logic [4:0] ev = 5'h0;
  logic [2:0] alarm = 3'h0;
  dsv_warn_t w = '0;
  dsv_state_t state;
  logic exe, sts, dgs;
  logic [7:0] sel;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_sts = 0;
  int n_dgs = 0;
  always #4 i_clock = ~i_clock;
  // Start pulses last one cycle, so count them as they pass
  always @(posedge i_clock) begin
    n_sts <= n_sts + int'(sts);
    n_dgs <= n_dgs + int'(dgs);
  end
  dsv_master_model dsv_master_model_i (.i_clock(i_clock),
    .i_rdata(rdat), .i_wait(wait_r), .o_addr(addr), .o_rd(rd_r),
    .o_wr(wr_r), .o_wdata(wdat), .o_be(be), .o_io_valid(io));
  dsv_supervisor #(.NUM_SENSORS(2)) dsv_supervisor_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_address(addr),
    .i_avs_read(rd_r), .i_avs_write(wr_r), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_r), .i_int_abort(ev[0]),
    .i_int_recover(ev[1]), .i_io_data_valid(io),
    .i_selftest_done(ev[2]), .i_selftest_pass(ev[3]),
    .i_crit_fault(ev[4]), .i_alarm_cond(alarm), .i_mem_warn(w.mem),
    .i_s1_status_ext(w.s1_ext), .i_s1_warn0(w.s1_w0),
    .i_s1_warn1(w.s1_w1), .i_s2_warn0(w.s2_w0), .i_s2_warn1(w.s2_w1),
    .i_serial_comm_warning_flag(w.sercom), .o_state(state),
    .o_executing(exe), .o_selftest_start(sts), .o_diag_start(dgs),
    .o_diagnostic_test_selector(sel));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    dsv_master_model_i.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    dsv_master_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic svc(input logic [7:0] c, a, v, output logic [31:0] r);
    wr(`DSV_OFS_CMD, {8'h00, v, a, c});
    rd(`DSV_OFS_RESULT, r);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    check(q, e);
  endtask
  task automatic st_is(input logic [2:0] s);
    rd_chk(`DSV_OFS_STATE, {29'h0, s});
    check({29'h0, state}, {29'h0, s});
  endtask
  task automatic svc_chk(input logic [7:0] c, a, st, input logic [2:0] s);
    logic [31:0] r;
    svc(c, a, 8'h00, r);
    check({24'h0, r[15:8]}, {24'h0, st});
    st_is(s);
  endtask
  // Event bits: abort, recover, done, pass, fault
  task automatic pulse(input logic [4:0] m);
    @(posedge i_clock);
    ev <= m;
    @(posedge i_clock);
    ev <= 5'h0;
    repeat (2) @(posedge i_clock);
  endtask
  task automatic cond(input logic [2:0] al, input dsv_warn_t v);
    @(posedge i_clock);
    alarm <= al;
    w <= v;
    repeat (2) @(posedge i_clock);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_boot();
    st_is(3'h0);
    rd_chk(`DSV_OFS_ENABLE, 32'h3);
    pulse(5'h0c);
    st_is(3'h1);
  endtask
  task automatic t_flow();
    svc_chk(`DSV_SVC_START, 8'h0, `DSV_ST_OK, 3'h2);
    svc_chk(`DSV_SVC_STOP, 8'h0, `DSV_ST_OK, 3'h1);
    dsv_master_model_i.io_poll();
    st_is(3'h2);
    check({31'h0, exe}, 32'h1);
    svc_chk(`DSV_SVC_ABORT, 8'h0, `DSV_ST_OK, 3'h3);
    svc_chk(`DSV_SVC_DIAG, 8'h0, `DSV_ST_CONFLICT, 3'h3);
    svc_chk(`DSV_SVC_RECOVER, 8'h0, `DSV_ST_OK, 3'h1);
    pulse(5'h01);
    st_is(3'h3);
    pulse(5'h02);
    st_is(3'h1);
    svc_chk(`DSV_SVC_DIAG, 8'h5a, `DSV_ST_OK, 3'h0);
    check({24'h0, sel}, 32'h5a);
    pulse(5'h0c);
    svc_chk(`DSV_SVC_RESET, 8'h0, `DSV_ST_OK, 3'h0);
    pulse(5'h0c);
    check(n_sts, 32'h2);
    check(n_dgs, 32'h1);
  endtask
  task automatic t_attr();
    logic [31:0] r;
    svc(`DSV_SVC_GET, `DSV_ATTR_STATE, 8'h00, r);
    check({16'h0, r[15:0]}, 32'h0001);
    svc(`DSV_SVC_SET, `DSV_ATTR_WARN_EN, 8'h00, r);
    check({24'h0, r[15:8]}, 32'h0);
    rd_chk(`DSV_OFS_ENABLE, 32'h1);
    svc(`DSV_SVC_SET, `DSV_ATTR_WARN_EN, 8'h01, r);
    svc(8'h33, 8'h00, 8'h00, r);
    check({24'h0, r[15:8]}, 32'h08);
    rd_chk(6'h3c, 32'h0);
  endtask
  task automatic t_warn();
    cond(3'h3, {3'h5, 8'h05, 8'ha5, 8'hbc, 8'hc3, 8'h5a, 1'b1});
    rd_chk(`DSV_OFS_EXC_STAT, 32'hf3);
    rd_chk(`DSV_OFS_WDET_COM, 32'h80001402);
    rd_chk(`DSV_OFS_WDET_DEVA, 32'hbca50505);
    rd_chk(`DSV_OFS_WDET_DEVB, 32'h80005ac3);
    rd_chk(`DSV_OFS_WDET_MFR, 32'h80000101);
    wr(`DSV_OFS_ENABLE, 32'h1);
    rd_chk(`DSV_OFS_EXC_STAT, 32'h83);
    rd_chk(`DSV_OFS_WDET_COM, 32'h0);
    wr(`DSV_OFS_ENABLE, 32'h2);
    rd_chk(`DSV_OFS_EXC_STAT, 32'hf0);
    wr(`DSV_OFS_ENABLE, 32'h3);
    cond(3'h0, '0);
    rd_chk(`DSV_OFS_EXC_STAT, 32'h80);
  endtask
  task automatic t_crit();
    pulse(5'h10);
    st_is(3'h4);
    svc_chk(`DSV_SVC_RESET, 8'h0, `DSV_ST_CONFLICT, 3'h4);
    svc_chk(`DSV_SVC_DIAG, 8'h0, `DSV_ST_CONFLICT, 3'h4);
    check(n_sts, 32'h2);
    check(n_dgs, 32'h1);
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    t_boot();
    t_flow();
    t_attr();
    t_warn();
    t_crit();
    wrap_up();
  end
  // Tests need well under 2000 cycles; this is ten times that
  initial begin
    #160000;
    n_mismatch++;
    wrap_up();
  end
endmodule
